//--- inc/lf_wake_pkg.sv
// constants for the low-frequency wake-up receiver status block
package lf_wake_pkg;
    // register offsets on the extended function register port
    localparam logic [7:0] SNIFF_TIMEOUT_LIMITS_ADDR = 8'hdc;
    localparam logic [7:0] CARRIER_DETECT_SETUP_ADDR = 8'hdd;
    localparam logic [7:0] FRONT_END_MONITOR_ADDR    = 8'he1;
    localparam logic [7:0] RECEIVED_BYTE_ADDR        = 8'he2;
    localparam logic [7:0] BIT_WIDTH_COUNT_ADDR      = 8'hec;
    localparam logic [7:0] RECEIVER_STATE_FLAGS_ADDR = 8'hc8;

    localparam logic [7:0] SNIFF_TIMEOUT_LIMITS_RST = 8'h00;
    localparam logic [4:0] CARRIER_DETECT_SETUP_RST = 5'h00;
    localparam logic [7:0] RECEIVED_BYTE_RST        = 8'h00;
    localparam logic [6:0] BIT_WIDTH_RST            = 7'h00;

    // field positions
    localparam int OVERALL_LSB   = 3;
    localparam int OVERALL_W     = 5;
    localparam int PREAMBLE_LSB  = 0;
    localparam int PREAMBLE_W    = 3;
    localparam int PREQUAL_BIT   = 4;
    localparam int CARRIER_W     = 5;

    // timing, in periods of the low_freq_oscillator
    localparam int LF_PERIOD_NS   = 3300;
    localparam int OVERALL_MULT   = 512;
    localparam int OVERALL_ADD    = 257;
    localparam int TICKS_PER_UNIT = 4;
    localparam int PREAMBLE_MULT  = 128;
    localparam int TIMER_W        = 17;
    localparam int PRE_QUAL_SHORT = 3;
    localparam int PRE_QUAL_LONG  = 5;
    localparam int SYNC_HEAD_ONES = 3;
    localparam int BYTE_BITS      = 8;
    localparam int OSC_DIV_BIT    = 4;   // bit 4 of a tick counter toggles every 16 ticks: osc / 32
    localparam int PRE_SYM_MIN    = 2;
    localparam int PRE_SYM_MAX    = 40;

    typedef enum logic [2:0] {
        st_idle,
        st_preamble,
        st_sync,
        st_data,
        st_aborted
    } rx_state_type;
endpackage

//--- src/pin_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

//--- src/lf_wake_receiver_status.sv
// status, timeout and register logic of the low-frequency wake-up receiver
`timescale 1ns/1ns
module lf_wake_receiver_status #(
    parameter int PRE_SYM_MIN = lf_wake_pkg::PRE_SYM_MIN,
    parameter int PRE_SYM_MAX = lf_wake_pkg::PRE_SYM_MAX
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // extended_function_regs port of the core
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // core-side controls
    input  wire logic       sniff_start,
    input  wire logic       mode_trim_sel,
    input  wire logic       wake_id_hit,
    // analogue front-end pins
    input  wire logic       low_freq_oscillator,
    input  wire logic       data_in,
    input  wire logic       carrier_out,
    input  wire logic       ready_amp,
    input  wire logic       rssi_vt,
    input  wire logic       rssi_avg,
    input  wire logic       sample_in,
    input  wire logic       trim_mon_offset,
    input  wire logic       trim_mon_lpf,
    // status outputs
    output logic            rx_abort,
    output logic            rx_ready
);
    localparam int NPIN = 9;
    localparam int TW   = lf_wake_pkg::TIMER_W;
    // every edge flips the line level, so a run of ones can only be carried by long symbols
    localparam int BIT_ONE_MIN = PRE_SYM_MAX / 2;

    logic [NPIN-1:0] pin_s;
    logic osc_s, data_s, carrier_s, ready_s, vt_s, avg_s, sample_s, trim_off_s, trim_lpf_s;

    pin_sync #(.WIDTH(NPIN)) u_pin_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .d        ({low_freq_oscillator, data_in, carrier_out, ready_amp, rssi_vt, rssi_avg, sample_in,
                    trim_mon_offset, trim_mon_lpf}),
        .q        (pin_s)
    );
    assign {osc_s, data_s, carrier_s, ready_s, vt_s, avg_s, sample_s, trim_off_s, trim_lpf_s} = pin_s;

    function automatic logic [TW-1:0] overall_limit(input logic [lf_wake_pkg::OVERALL_W-1:0] f);
        overall_limit = TW'((TW'(f) * TW'(lf_wake_pkg::OVERALL_MULT) + TW'(lf_wake_pkg::OVERALL_ADD))
                            * TW'(lf_wake_pkg::TICKS_PER_UNIT));
    endfunction

    function automatic logic [TW-1:0] preamble_limit(input logic [lf_wake_pkg::PREAMBLE_W-1:0] f);
        preamble_limit = TW'(TW'(f) * TW'(lf_wake_pkg::PREAMBLE_MULT) * TW'(lf_wake_pkg::TICKS_PER_UNIT));
    endfunction

    // registers
    logic [7:0]                 limits_ff, nxt_limits;
    logic [lf_wake_pkg::CARRIER_W-1:0] carrier_setup_ff, nxt_carrier_setup;
    logic [7:0]                 rdata_ff, nxt_rdata;
    logic [7:0]                 rx_byte_ff, nxt_rx_byte;
    logic [7:0]                 shift_ff, nxt_shift;
    logic [2:0]                 bit_cnt_ff, nxt_bit_cnt;
    logic [6:0]                 width_ff, nxt_width;
    logic [6:0]                 width_cnt_ff, nxt_width_cnt;
    logic [TW-1:0]              overall_cnt_ff, nxt_overall_cnt;
    logic [TW-1:0]              pre_cnt_ff, nxt_pre_cnt;
    logic [2:0]                 sym_cnt_ff, nxt_sym_cnt;
    logic [1:0]                 ones_cnt_ff, nxt_ones_cnt;
    logic [lf_wake_pkg::OSC_DIV_BIT:0] div_ff, nxt_div;
    logic                       osc_prev_ff, data_prev_ff;
    logic                       ready_ff, nxt_ready;
    logic                       data_valid_ff, nxt_data_valid;
    logic                       id_valid_ff, nxt_id_valid;
    logic                       sync_valid_ff, nxt_sync_valid;
    logic                       head_valid_ff, nxt_head_valid;
    logic                       pre_valid_ff, nxt_pre_valid;
    logic                       abort_ff, nxt_abort;
    lf_wake_pkg::rx_state_type  state_ff, nxt_state;

    logic       osc_tick, data_edge, bit_val, sym_ok, time_up, pre_up;
    logic [2:0] qual_need;
    logic [7:0] fe_monitor, state_flags;
    logic [lf_wake_pkg::OVERALL_W-1:0]  overall_field;
    logic [lf_wake_pkg::PREAMBLE_W-1:0] preamble_field;

    assign osc_tick       = osc_s & ~osc_prev_ff;
    assign data_edge      = data_s ^ data_prev_ff;
    assign bit_val        = width_cnt_ff > 7'(BIT_ONE_MIN);
    assign overall_field  = limits_ff[lf_wake_pkg::OVERALL_LSB +: lf_wake_pkg::OVERALL_W];
    assign preamble_field = limits_ff[lf_wake_pkg::PREAMBLE_LSB +: lf_wake_pkg::PREAMBLE_W];
    assign time_up        = overall_cnt_ff >= overall_limit(overall_field);
    assign pre_up         = (state_ff == lf_wake_pkg::st_preamble) && (preamble_field != '0)
                            && (pre_cnt_ff >= preamble_limit(preamble_field));
    assign sym_ok         = (width_cnt_ff >= 7'(PRE_SYM_MIN)) && (width_cnt_ff <= 7'(PRE_SYM_MAX));
    assign qual_need      = carrier_setup_ff[lf_wake_pkg::PREQUAL_BIT] ? 3'(lf_wake_pkg::PRE_QUAL_SHORT)
                                                                        : 3'(lf_wake_pkg::PRE_QUAL_LONG);

    // live monitor bits are the synchronised pins; trim source follows the mode bit
    assign fe_monitor  = {ready_s, mode_trim_sel ? trim_lpf_s : trim_off_s,
                          vt_s, avg_s, carrier_s, osc_s, sample_s, data_s};
    assign state_flags = {ready_ff, data_valid_ff, id_valid_ff, sync_valid_ff, head_valid_ff,
                          pre_valid_ff, abort_ff, div_ff[lf_wake_pkg::OSC_DIV_BIT]};

    always_comb begin
        nxt_limits        = limits_ff;
        nxt_carrier_setup = carrier_setup_ff;
        nxt_rdata         = rdata_ff;
        nxt_rx_byte       = rx_byte_ff;
        nxt_shift         = shift_ff;
        nxt_bit_cnt       = bit_cnt_ff;
        nxt_width         = width_ff;
        nxt_width_cnt     = width_cnt_ff;
        nxt_overall_cnt   = overall_cnt_ff;
        nxt_pre_cnt       = pre_cnt_ff;
        nxt_sym_cnt       = sym_cnt_ff;
        nxt_ones_cnt      = ones_cnt_ff;
        nxt_div           = osc_tick ? div_ff + 1'b1 : div_ff;
        nxt_ready         = ready_ff;
        nxt_data_valid    = data_valid_ff;
        nxt_id_valid      = id_valid_ff;
        nxt_sync_valid    = sync_valid_ff;
        nxt_head_valid    = head_valid_ff;
        nxt_pre_valid     = pre_valid_ff;
        nxt_abort         = abort_ff;
        nxt_state         = state_ff;

        // register port
        if (sfr_wr) begin
            if (sfr_addr == lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_ADDR) begin
                nxt_limits = sfr_wdata;
            end
            if (sfr_addr == lf_wake_pkg::CARRIER_DETECT_SETUP_ADDR) begin
                nxt_carrier_setup = sfr_wdata[lf_wake_pkg::CARRIER_W-1:0];
            end
        end
        if (sfr_rd) begin
            unique case (sfr_addr)
                lf_wake_pkg::CARRIER_DETECT_SETUP_ADDR: nxt_rdata = 8'(carrier_setup_ff);
                lf_wake_pkg::FRONT_END_MONITOR_ADDR:    nxt_rdata = fe_monitor;
                lf_wake_pkg::RECEIVED_BYTE_ADDR:        nxt_rdata = rx_byte_ff;
                lf_wake_pkg::BIT_WIDTH_COUNT_ADDR:      nxt_rdata = {id_valid_ff, width_ff};
                lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR: nxt_rdata = state_flags;
                default:                                nxt_rdata = 8'h00;
            endcase
            // reading the byte hands it over; a new byte in the same cycle still sets it below
            if (sfr_addr == lf_wake_pkg::RECEIVED_BYTE_ADDR) begin
                nxt_ready = 1'b0;
            end
        end

        // bit width in oscillator periods, latched at each data edge; the counter saturates so an over-long symbol reads full scale
        if (data_edge) begin
            nxt_width     = width_cnt_ff;
            nxt_width_cnt = '0;
        end else if (osc_tick && width_cnt_ff != '1) begin
            nxt_width_cnt = width_cnt_ff + 1'b1;
        end

        if (wake_id_hit && state_ff != lf_wake_pkg::st_idle && state_ff != lf_wake_pkg::st_aborted) begin
            nxt_id_valid = 1'b1;
        end

        if (state_ff != lf_wake_pkg::st_idle && state_ff != lf_wake_pkg::st_aborted && osc_tick) begin
            nxt_overall_cnt = overall_cnt_ff + 1'b1;
            if (state_ff == lf_wake_pkg::st_preamble) begin
                nxt_pre_cnt = pre_cnt_ff + 1'b1;
            end
        end

        unique case (state_ff)
            lf_wake_pkg::st_idle, lf_wake_pkg::st_aborted: begin
            end
            lf_wake_pkg::st_preamble: begin
                if (data_edge) begin
                    if (!sym_ok) begin
                        nxt_sym_cnt = '0;
                    end else if (sym_cnt_ff + 1'b1 >= qual_need) begin
                        nxt_pre_valid = 1'b1;
                        nxt_sym_cnt   = '0;
                        nxt_state     = lf_wake_pkg::st_sync;
                    end else begin
                        nxt_sym_cnt = sym_cnt_ff + 1'b1;
                    end
                end
            end
            lf_wake_pkg::st_sync: begin
                if (data_edge) begin
                    if (bit_val) begin
                        nxt_ones_cnt = (ones_cnt_ff == 2'(lf_wake_pkg::SYNC_HEAD_ONES)) ? ones_cnt_ff
                                                                                         : ones_cnt_ff + 1'b1;
                        if (ones_cnt_ff + 1'b1 == 2'(lf_wake_pkg::SYNC_HEAD_ONES)) begin
                            nxt_head_valid = 1'b1;
                        end
                    end else if (head_valid_ff) begin
                        nxt_sync_valid = 1'b1;
                        nxt_state      = lf_wake_pkg::st_data;
                    end else begin
                        nxt_ones_cnt = '0;
                    end
                end
            end
            lf_wake_pkg::st_data: begin
                if (data_edge) begin
                    nxt_shift   = {shift_ff[6:0], bit_val};
                    nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    if (bit_cnt_ff == 3'(lf_wake_pkg::BYTE_BITS - 1)) begin
                        nxt_rx_byte    = {shift_ff[6:0], bit_val};
                        nxt_ready      = 1'b1;
                        nxt_data_valid = id_valid_ff;
                    end
                end
            end
        endcase

        // timeouts halt the attempt; the flag stays until the next start
        if (state_ff != lf_wake_pkg::st_idle && state_ff != lf_wake_pkg::st_aborted && (time_up || pre_up)) begin
            nxt_abort = 1'b1;
            nxt_state = lf_wake_pkg::st_aborted;
        end

        if (sniff_start) begin
            nxt_state       = lf_wake_pkg::st_preamble;
            nxt_abort       = 1'b0;
            nxt_overall_cnt = '0;
            nxt_pre_cnt     = '0;
            nxt_sym_cnt     = '0;
            nxt_ones_cnt    = '0;
            nxt_bit_cnt     = '0;
            nxt_pre_valid   = 1'b0;
            nxt_head_valid  = 1'b0;
            nxt_sync_valid  = 1'b0;
            nxt_id_valid    = 1'b0;
            nxt_data_valid  = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            limits_ff        <= lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_RST;
            carrier_setup_ff <= lf_wake_pkg::CARRIER_DETECT_SETUP_RST;
            rdata_ff         <= 8'h00;
            rx_byte_ff       <= lf_wake_pkg::RECEIVED_BYTE_RST;
            shift_ff         <= 8'h00;
            bit_cnt_ff       <= 3'h0;
            width_ff         <= lf_wake_pkg::BIT_WIDTH_RST;
            width_cnt_ff     <= 7'h00;
            overall_cnt_ff   <= '0;
            pre_cnt_ff       <= '0;
            sym_cnt_ff       <= 3'h0;
            ones_cnt_ff      <= 2'h0;
            div_ff           <= '0;
            osc_prev_ff      <= 1'b0;
            data_prev_ff     <= 1'b0;
            ready_ff         <= 1'b0;
            data_valid_ff    <= 1'b0;
            id_valid_ff      <= 1'b0;
            sync_valid_ff    <= 1'b0;
            head_valid_ff    <= 1'b0;
            pre_valid_ff     <= 1'b0;
            abort_ff         <= 1'b0;
            state_ff         <= lf_wake_pkg::st_idle;
        end else begin
            limits_ff        <= nxt_limits;
            carrier_setup_ff <= nxt_carrier_setup;
            rdata_ff         <= nxt_rdata;
            rx_byte_ff       <= nxt_rx_byte;
            shift_ff         <= nxt_shift;
            bit_cnt_ff       <= nxt_bit_cnt;
            width_ff         <= nxt_width;
            width_cnt_ff     <= nxt_width_cnt;
            overall_cnt_ff   <= nxt_overall_cnt;
            pre_cnt_ff       <= nxt_pre_cnt;
            sym_cnt_ff       <= nxt_sym_cnt;
            ones_cnt_ff      <= nxt_ones_cnt;
            div_ff           <= nxt_div;
            osc_prev_ff      <= osc_s;
            data_prev_ff     <= data_s;
            ready_ff         <= nxt_ready;
            data_valid_ff    <= nxt_data_valid;
            id_valid_ff      <= nxt_id_valid;
            sync_valid_ff    <= nxt_sync_valid;
            head_valid_ff    <= nxt_head_valid;
            pre_valid_ff     <= nxt_pre_valid;
            abort_ff         <= nxt_abort;
            state_ff         <= nxt_state;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign rx_abort  = abort_ff;
    assign rx_ready  = ready_ff;
endmodule

//--- testbench/lf_status_checker_asserts.sv
// concurrent checks on the ports of the wake-up receiver status block
`timescale 1ns/1ns
module lf_status_checker (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sniff_start,
    input wire logic       mode_trim_sel,
    input wire logic       carrier_out,
    input wire logic       trim_mon_offset,
    input wire logic       trim_mon_lpf,
    input wire logic       rx_abort
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic rd_mon;
    assign rd_mon = sfr_rd && (sfr_addr == lf_wake_pkg::FRONT_END_MONITOR_ADDR);

    a_abort_holds: assert property (rx_abort && !sniff_start |=> rx_abort)
        else $error("abort flag dropped without a restart");
    a_start_clears: assert property (sniff_start |=> !rx_abort)
        else $error("abort flag survived a restart");
    // the shortest timeout is hundreds of oscillator ticks, so eight clocks is always safe
    a_no_early_abort: assert property (sniff_start |=> (!rx_abort)[*8])
        else $error("abort raised right after a restart");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_limits_wo: assert property (
        sfr_rd && sfr_addr == lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_ADDR |=> sfr_rdata == 8'h00)
        else $error("write-only limits read back nonzero");
    a_setup_top: assert property (
        sfr_rd && sfr_addr == lf_wake_pkg::CARRIER_DETECT_SETUP_ADDR |=> sfr_rdata[7:5] == 3'h0)
        else $error("unused carrier setup bits read nonzero");
    a_trim_offset: assert property ((!mode_trim_sel && trim_mon_offset)[*4] ##0 rd_mon |=> sfr_rdata[6])
        else $error("trim monitor ignores the offset source");
    a_trim_filter: assert property ((mode_trim_sel && !trim_mon_lpf)[*4] ##0 rd_mon |=> !sfr_rdata[6])
        else $error("trim monitor ignores the filter source");
    a_carrier_mirror: assert property (carrier_out[*4] ##0 rd_mon |=> sfr_rdata[3])
        else $error("carrier level missing from monitor");

    c_abort: cover property ($rose(rx_abort));
    c_monitor: cover property (rd_mon);
    c_restart: cover property (rx_abort ##1 sniff_start);
endmodule

bind lf_wake_receiver_status lf_status_checker lf_status_checker_i (
    .core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sniff_start(sniff_start), .mode_trim_sel(mode_trim_sel), .carrier_out(carrier_out),
    .trim_mon_offset(trim_mon_offset), .trim_mon_lpf(trim_mon_lpf), .rx_abort(rx_abort)
);

//--- testbench/lf_transmitter.sv
// behavioural far side: oscillator, demodulated data and carrier pins
`timescale 1ns/1ns
module lf_transmitter #(
    parameter int HALF_NS = 83
) (
    output logic low_freq_oscillator,
    output logic data_in,
    output logic carrier_out
);
    // oscillator runs far faster than 300 kHz so the long timeouts fit a short run
    int   ticks = 0;
    logic run   = 1'b1;

    initial begin
        low_freq_oscillator = 1'b0;
        data_in = 1'b0;
        carrier_out = 1'b0;
    end

    always begin
        #HALF_NS;
        if (run) begin
            low_freq_oscillator = ~low_freq_oscillator;
        end
    end

    always @(posedge low_freq_oscillator) begin
        ticks++;
    end

    // each data edge closes one symbol of w oscillator periods
    task automatic symbols(input int n, input int w);
        repeat (n) begin
            repeat (w) @(posedge low_freq_oscillator);
            #30;
            data_in = ~data_in;
        end
    endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the wake-up receiver status block
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    logic       core_clk = 1'b0;
    logic       resetn;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    wire  [7:0] sfr_rdata;
    logic       sniff_start;
    logic       mode_trim_sel;
    logic       wake_id_hit;
    wire        low_freq_oscillator;
    wire        data_in;
    wire        carrier_out;
    logic       ready_amp, rssi_vt, rssi_avg, sample_in, trim_mon_offset, trim_mon_lpf;
    wire        rx_abort;
    wire        rx_ready;
    logic [7:0] d;
    logic [7:0] p;
    logic [7:0] pat [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
    int         err_total = 0;
    int         n_compared = 0;

    always #10 core_clk = ~core_clk;

    lf_transmitter lf_transmitter_i (.low_freq_oscillator(low_freq_oscillator), .data_in(data_in), .carrier_out(carrier_out));

    lf_wake_receiver_status lf_wake_receiver_status_i (
        .core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sniff_start(sniff_start),
        .mode_trim_sel(mode_trim_sel), .wake_id_hit(wake_id_hit), .low_freq_oscillator(low_freq_oscillator), .data_in(data_in),
        .carrier_out(carrier_out), .ready_amp(ready_amp), .rssi_vt(rssi_vt), .rssi_avg(rssi_avg),
        .sample_in(sample_in), .trim_mon_offset(trim_mon_offset), .trim_mon_lpf(trim_mon_lpf),
        .rx_abort(rx_abort), .rx_ready(rx_ready)
    );

    task automatic close_out;
        $display("comparisons=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask

    task automatic start;
        @(negedge core_clk);
        sniff_start = 1'b1;
        @(negedge core_clk);
        sniff_start = 1'b0;
    endtask

    // abort must land within one tick of the expected count, allowing for pin latency
    task automatic timeout_case(input logic [7:0] lim, input int exp);
        int t0;
        int n;
        logic [7:0] s;
        wr(lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_ADDR, lim);
        start();
        t0 = lf_transmitter_i.ticks;
        n = 0;
        while (rx_abort !== 1'b1 && n < exp * 12) begin
            @(negedge core_clk);
            n++;
        end
        n = lf_transmitter_i.ticks - t0;
        `CHK(n >= exp - 1 && n <= exp + 1, 1'b1)
        rd(lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR, s);
        `CHK(s[1], 1'b1)
    endtask

    initial begin
        {resetn, sfr_wr, sfr_rd, sniff_start, mode_trim_sel, wake_id_hit} = 6'h00;
        {ready_amp, rssi_vt, rssi_avg, sample_in, trim_mon_offset, trim_mon_lpf} = 6'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        rd(lf_wake_pkg::RECEIVED_BYTE_ADDR, d);
        `CHK(d, lf_wake_pkg::RECEIVED_BYTE_RST)
        rd(lf_wake_pkg::BIT_WIDTH_COUNT_ADDR, d);
        `CHK(d, 8'h00)
        rd(lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR, d);
        `CHK(d[7:1], 7'h00)
        wr(lf_wake_pkg::RECEIVED_BYTE_ADDR, 8'ha5);
        rd(lf_wake_pkg::RECEIVED_BYTE_ADDR, d);
        `CHK(d, 8'h00)
        wr(lf_wake_pkg::CARRIER_DETECT_SETUP_ADDR, 8'hff);
        rd(lf_wake_pkg::CARRIER_DETECT_SETUP_ADDR, d);
        `CHK(d, 8'h1f)
        wr(lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_ADDR, 8'hff);
        rd(lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_ADDR, d);
        `CHK(d, 8'h00)
        rd(8'h55, d);
        `CHK(d, 8'h00)
        // freeze the oscillator so its level is known when the monitor is read
        lf_transmitter_i.run = 1'b0;
        for (int i = 0; i < 4; i++) begin
            p = pat[i];
            @(negedge core_clk);
            mode_trim_sel = i[0];
            {ready_amp, rssi_vt, rssi_avg, sample_in} = {p[7], p[5], p[4], p[1]};
            trim_mon_offset = p[6] ^ i[0];
            trim_mon_lpf = p[6] ^ ~i[0];
            lf_transmitter_i.carrier_out = p[3];
            lf_transmitter_i.data_in = p[0];
            repeat (4) @(negedge core_clk);
            rd(lf_wake_pkg::FRONT_END_MONITOR_ADDR, d);
            `CHK(d, {p[7:3], lf_transmitter_i.low_freq_oscillator, p[1:0]})
        end
        lf_transmitter_i.run = 1'b1;
        wr(lf_wake_pkg::SNIFF_TIMEOUT_LIMITS_ADDR, 8'h00);
        for (int q = 1; q >= 0; q--) begin
            wr(lf_wake_pkg::CARRIER_DETECT_SETUP_ADDR, {3'h0, q[0], 4'h5});
            start();
            lf_transmitter_i.symbols((q == 1) ? 2 : 4, 8);
            repeat (6) @(negedge core_clk);
            rd(lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR, d);
            `CHK(d[2], 1'b0)
            lf_transmitter_i.symbols(1, 8);
            repeat (6) @(negedge core_clk);
            rd(lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR, d);
            `CHK(d[2], 1'b1)
            rd(lf_wake_pkg::BIT_WIDTH_COUNT_ADDR, d);
            `CHK(d[6:0] >= 7'h07 && d[6:0] <= 7'h0a, 1'b1)
        end
        @(negedge core_clk);
        wake_id_hit = 1'b1;
        @(negedge core_clk);
        wake_id_hit = 1'b0;
        rd(lf_wake_pkg::BIT_WIDTH_COUNT_ADDR, d);
        `CHK(d[7], 1'b1)
        // sync head of three long symbols, a short one, then one byte, long symbols being ones
        lf_transmitter_i.symbols(3, 30);
        lf_transmitter_i.symbols(1, 8);
        p = 8'ha5;
        for (int b = 7; b >= 0; b--) begin
            lf_transmitter_i.symbols(1, p[b] ? 30 : 8);
        end
        repeat (6) @(negedge core_clk);
        `CHK(rx_ready, 1'b1)
        rd(lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR, d);
        `CHK(d[7:1], 7'h7e)
        rd(lf_wake_pkg::RECEIVED_BYTE_ADDR, d);
        `CHK(d, p)
        `CHK(rx_ready, 1'b0)
        timeout_case(8'h01, 512);
        lf_transmitter_i.symbols(6, 8);
        repeat (6) @(negedge core_clk);
        rd(lf_wake_pkg::RECEIVER_STATE_FLAGS_ADDR, d);
        `CHK(d[2:1], 2'h1)
        start();
        `CHK(rx_abort, 1'b0)
        timeout_case(8'h00, 1028);
        timeout_case(8'h02, 1024);
        timeout_case(8'h07, 1028);
        timeout_case(8'h08, 3076);
        close_out();
    end

    initial begin
        #1_800_000;
        err_total++;
        close_out();
    end
endmodule
